// ==== src/tdm_audio_serial_port.sv ====
// Notes on behaviour
// - Frame starts at chosen frame-sync edge polarity
// - Frame sync and data sampled on chosen edge
// - Five-bit delay from frame edge to slot 0
// - Receive slot is 16, 24 or 32 bits
// - Word taken left or right justified
// - Default mono slot equals address pin offset
// - Override source: left, right or downmix average
// - Slot beyond frame end gives muted sample
// - Transmit bits launched on chosen clock edge
// - Three-bit delay from frame to transmit slot 0
// - Idle bits drive zero or float
// - Optional weak keeper, disable bit turns off
// - Keeper holds one LSB or permanently
// - Final LSB driven full or half cycle
// - Boost and battery streams: enable, length, slot
// - Die temperature stream at its slot
// - Health word sent at its slot when enabled
// - Health word carries eight fixed status bits
// - Transmit words cut at frame boundary
// - Pin loopback copies input straight to output
// - Deserialiser loopback reserialises decoded input
// - Echo reference stream with own length, slot
// - Slots per frame detected automatically
// - Detected sample rate reported read-only
`timescale 1ns/1ps
`default_nettype none
`include "tdm_cfg.svh"
module tdm_audio_serial_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_bit_clock_i,
  input wire logic frame_sync_i,
  input wire logic serial_data_input_i,
  input wire logic address_select_pin_a_i,
  input wire logic address_select_pin_b_i,
  input wire tdm_pkg::tx_streams_s streams_i,
  output logic [31:0] playback_sample_o,
  output logic playback_valid_o,
  output logic serial_data_output_o,
  output logic serial_data_output_oe_o,
  output logic keeper_oe_o
);
  localparam int NS = 6;

  logic [31:0] ctrl_q, tx_slots_q;
  logic [7:0] rx_slots_q;
  logic [10:0] tx_en_q;
  logic [31:0] tx_en_m;
  logic [5:0] echo_slot_q;
  logic [31:0] rdata;
  logic bclk_s, fs_s, sd_s, ad_a_s, ad_b_s, bclk_d_q;
  logic rise, fall, rx_tick, tx_tick, tx_half;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic [5:0] slot_bits(input logic [1:0] code);
    if (code == 2'h0) slot_bits = `BITS_16;
    else if (code == 2'h1) slot_bits = `BITS_24;
    else slot_bits = `BITS_32;
  endfunction

  function automatic logic [5:0] word_bits(input logic [1:0] code);
    if (code == 2'h0) word_bits = `BITS_16;
    else if (code == 2'h1) word_bits = `BITS_20;
    else if (code == 2'h2) word_bits = `BITS_24;
    else word_bits = `BITS_32;
  endfunction

  // Result is MSB aligned so later stages see one two's complement format
  function automatic logic [31:0] extract(input logic [31:0] sh, input logic [5:0] sl,
                                          input logic [5:0] wl, input logic right);
    logic [31:0] a;
    a = right ? sh : (sh >> (sl - wl));
    extract = a << (`BITS_32 - wl);
  endfunction

  // Bus clock and pins
  tdm_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({serial_bit_clock_i, frame_sync_i, serial_data_input_i,
          address_select_pin_a_i, address_select_pin_b_i}),
    .q_o({bclk_s, fs_s, sd_s, ad_a_s, ad_b_s})
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) bclk_d_q <= 1'b0;
    else bclk_d_q <= bclk_s;
  end

  assign rise = bclk_s & ~bclk_d_q;
  assign fall = ~bclk_s & bclk_d_q;
  assign rx_tick = ctrl_q[`F_RX_EDGE] ? fall : rise;
  assign tx_tick = ctrl_q[`F_TX_EDGE] ? fall : rise;
  assign tx_half = ctrl_q[`F_TX_EDGE] ? rise : fall;
  assign tx_en_m = merge({21'h00_0000, tx_en_q}, wb_dat_i, wb_sel_i);

  // Wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) wb_dat_o <= rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RESET;
      rx_slots_q <= '0;
      tx_en_q <= '0;
      tx_slots_q <= '0;
      echo_slot_q <= '0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
      // Write lands on the edge at which the master sees ack
      if (wb_adr_i == `OFS_CTRL) ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OFS_RX_SLOTS) rx_slots_q <= wb_sel_i[0] ? wb_dat_i[7:0] : rx_slots_q;
      else if (wb_adr_i == `OFS_TX_ENABLE) tx_en_q <= tx_en_m[10:0];
      else if (wb_adr_i == `OFS_TX_SLOTS) tx_slots_q <= merge(tx_slots_q, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OFS_ECHO_SLOT) echo_slot_q <= wb_sel_i[0] ? wb_dat_i[5:0] : echo_slot_q;
    end
  end

  // Receive framing
  tdm_pkg::rx_phase_e phase_q, phase_d;
  logic fs_prev_q, start, at_delay, in_slot;
  logic [9:0] pos_q, cur_pos;
  logic [5:0] sbit_q, sbit_d, sidx_q, sidx_d, slen, wlen, slots_q;
  logic [4:0] rx_delay;
  logic [1:0] scfg;
  logic [3:0] sel_a, sel_b;
  logic [31:0] sh_a_q, sh_b_q, word_a_q, word_b_q, sh_a_d, sh_b_d;
  logic done_a_q, done_b_q;
  logic [32:0] mix;
  logic [2:0] rate;

  assign rx_delay = ctrl_q[`F_RX_DELAY +: 5];
  assign slen = slot_bits(ctrl_q[`F_RX_SLOT_LENGTH +: 2]);
  assign wlen = word_bits(ctrl_q[`F_RX_WORD_LENGTH +: 2]);
  assign scfg = ctrl_q[`F_RX_SOURCE_CONFIG +: 2];
  // Mono default follows the address pins, else the chosen left or right slot
  assign sel_a = (scfg == `SCFG_ADDR) ? {2'b00, ad_b_s, ad_a_s} :
                 (scfg == `SCFG_RIGHT) ? rx_slots_q[`F_SLOT_R +: 4] :
                 rx_slots_q[`F_SLOT_L +: 4];
  assign sel_b = rx_slots_q[`F_SLOT_R +: 4];
  assign sh_a_d = {sh_a_q[30:0], sd_s};
  assign sh_b_d = {sh_b_q[30:0], sd_s};
  assign mix = {word_a_q[31], word_a_q} + {word_b_q[31], word_b_q};

  always_comb begin
    start = rx_tick && (fs_s != fs_prev_q) && (fs_s == ctrl_q[`F_FRAME_POL]);
    cur_pos = start ? 10'h000 : ((pos_q == 10'h3FF) ? pos_q : pos_q + 10'h001);
    at_delay = (cur_pos == {5'h00, rx_delay});
    if (start) phase_d = at_delay ? tdm_pkg::SLOTS : tdm_pkg::OFFSET;
    else if (phase_q == tdm_pkg::OFFSET && at_delay) phase_d = tdm_pkg::SLOTS;
    else phase_d = phase_q;
    in_slot = (phase_d == tdm_pkg::SLOTS);
    if (at_delay && (start || phase_q == tdm_pkg::OFFSET)) begin
      sbit_d = '0;
      sidx_d = '0;
    end else if (sbit_q == slen - 6'h01) begin
      sbit_d = '0;
      sidx_d = (sidx_q == 6'h3F) ? sidx_q : sidx_q + 6'h01;
    end else begin
      sbit_d = sbit_q + 6'h01;
      sidx_d = sidx_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle level ahead of a default high-to-low frame edge, so frame one counts
      fs_prev_q <= 1'b1;
      pos_q <= '0;
      phase_q <= tdm_pkg::WAIT_FRAME;
      sbit_q <= '0;
      sidx_q <= '0;
      slots_q <= '0;
    end else if (rx_tick) begin
      fs_prev_q <= fs_s;
      pos_q <= cur_pos;
      phase_q <= phase_d;
      if (in_slot) begin
        sbit_q <= sbit_d;
        sidx_q <= sidx_d;
      end
      // Completed slots of the closing frame
      if (start && phase_q == tdm_pkg::SLOTS)
        slots_q <= (sbit_q == slen - 6'h01) ? sidx_q + 6'h01 : sidx_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_a_q <= '0;
      sh_b_q <= '0;
      word_a_q <= '0;
      word_b_q <= '0;
      done_a_q <= 1'b0;
      done_b_q <= 1'b0;
    end else if (rx_tick) begin
      if (start) begin
        done_a_q <= 1'b0;
        done_b_q <= 1'b0;
      end
      if (in_slot && sidx_d == {2'b00, sel_a}) begin
        sh_a_q <= sh_a_d;
        if (sbit_d == slen - 6'h01) begin
          word_a_q <= extract(sh_a_d, slen, wlen, ctrl_q[`F_RX_JUSTIFY]);
          done_a_q <= 1'b1;
        end
      end
      if (in_slot && sidx_d == {2'b00, sel_b}) begin
        sh_b_q <= sh_b_d;
        if (sbit_d == slen - 6'h01) begin
          word_b_q <= extract(sh_b_d, slen, wlen, ctrl_q[`F_RX_JUSTIFY]);
          done_b_q <= 1'b1;
        end
      end
    end
  end

  // A slot that did not complete before the next frame edge plays as mute
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      playback_valid_o <= 1'b0;
      playback_sample_o <= '0;
    end else begin
      playback_valid_o <= rx_tick && start && phase_q != tdm_pkg::WAIT_FRAME;
      if (rx_tick && start && phase_q != tdm_pkg::WAIT_FRAME) begin
        if (scfg == `SCFG_DOWNMIX)
          playback_sample_o <= (done_a_q && done_b_q) ? mix[32:1] : '0;
        else
          playback_sample_o <= done_a_q ? word_a_q : '0;
      end
    end
  end

  tdm_rate_detect u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .frame_i(start),
    .rate_o(rate)
  );

  always_comb begin
    if (wb_adr_i == `OFS_CTRL) rdata = ctrl_q;
    else if (wb_adr_i == `OFS_RX_SLOTS) rdata = {24'h00_0000, rx_slots_q};
    else if (wb_adr_i == `OFS_TX_ENABLE) rdata = {21'h00_0000, tx_en_q};
    else if (wb_adr_i == `OFS_TX_SLOTS) rdata = tx_slots_q;
    else if (wb_adr_i == `OFS_ECHO_SLOT) rdata = {26'h000_0000, echo_slot_q};
    else if (wb_adr_i == `OFS_STATUS) rdata = {18'h0_0000, slots_q, 5'h00, rate};
    else if (wb_adr_i == `OFS_PLAYBACK) rdata = playback_sample_o;
    else rdata = '0;
  end

  // Transmit side
  logic tx_pend_q, hit, bitv, is_last, t_ok;
  logic [9:0] tpos_q, tcur, tq, off;
  tdm_pkg::tx_streams_s words_q;
  logic [9:0] st_start [NS];
  logic [5:0] st_len [NS];
  logic [31:0] st_word [NS];
  logic [NS-1:0] st_en;
  logic drove_q, last_q, pin_loop, fill, kdis;

  assign pin_loop = ctrl_q[`F_PIN_LOOP];
  assign fill = ctrl_q[`F_TX_FILL];
  assign kdis = ctrl_q[`F_KEEP_DIS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pend_q <= 1'b0;
      tpos_q <= '0;
      words_q <= '0;
    end else begin
      if (start) tx_pend_q <= 1'b1;
      else if (tx_tick) tx_pend_q <= 1'b0;
      if (start) words_q <= streams_i;
      if (tx_tick) begin
        tpos_q <= tcur;
      end
    end
  end

  // Lower table entries win when programmed slots overlap
  always_comb begin
    tcur = tx_pend_q ? 10'h000 : ((tpos_q == 10'h3FF) ? tpos_q : tpos_q + 10'h001);
    t_ok = tcur >= {7'h00, ctrl_q[`F_TX_DELAY +: 3]};
    tq = tcur - {7'h00, ctrl_q[`F_TX_DELAY +: 3]};
    st_en = {ctrl_q[`F_DESER_LOOP], tx_en_q[`F_EN_ECHO], tx_en_q[`F_EN_HEALTH],
             tx_en_q[`F_EN_TEMP], tx_en_q[`F_EN_BATT], tx_en_q[`F_EN_BOOST]};
    st_start[0] = {1'b0, tx_slots_q[`F_SLOT_BOOST +: 6], 3'b000};
    st_len[0] = tx_en_q[`F_LEN_BOOST] ? `BITS_8 : `BITS_16;
    st_word[0] = {words_q.boost_supply, 16'h0000};
    st_start[1] = {1'b0, tx_slots_q[`F_SLOT_BATT +: 6], 3'b000};
    st_len[1] = tx_en_q[`F_LEN_BATT] ? `BITS_8 : `BITS_16;
    st_word[1] = {words_q.battery, 16'h0000};
    st_start[2] = {1'b0, tx_slots_q[`F_SLOT_TEMP +: 6], 3'b000};
    st_len[2] = `BITS_16;
    st_word[2] = {words_q.die_temperature, 16'h0000};
    st_start[3] = {1'b0, tx_slots_q[`F_SLOT_HEALTH +: 6], 3'b000};
    st_len[3] = `BITS_8;
    st_word[3] = {words_q.health, 24'h00_0000};
    st_start[4] = {1'b0, echo_slot_q, 3'b000};
    st_len[4] = tx_en_q[`F_LEN_ECHO] ? `BITS_16 : `BITS_32;
    st_word[4] = words_q.echo_reference;
    st_start[5] = '0;
    st_len[5] = `BITS_32;
    st_word[5] = playback_sample_o;
    hit = 1'b0;
    bitv = 1'b0;
    is_last = 1'b0;
    off = '0;
    for (int i = 0; i < NS; i++) begin
      if (!hit && st_en[i] && t_ok && tq >= st_start[i] &&
          (tq - st_start[i]) < {4'h0, st_len[i]}) begin
        hit = 1'b1;
        off = tq - st_start[i];
        bitv = st_word[i][5'd31 - off[4:0]];
        is_last = (off == {4'h0, st_len[i]} - 10'h001);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_data_output_o <= 1'b0;
      serial_data_output_oe_o <= 1'b0;
      keeper_oe_o <= 1'b0;
      last_q <= 1'b0;
      drove_q <= 1'b0;
    end else if (pin_loop) begin
      serial_data_output_o <= sd_s;
      serial_data_output_oe_o <= 1'b1;
      keeper_oe_o <= 1'b0;
      last_q <= 1'b0;
      drove_q <= 1'b0;
    end else if (tx_tick) begin
      drove_q <= hit;
      last_q <= hit && is_last;
      if (hit) begin
        serial_data_output_o <= bitv;
        serial_data_output_oe_o <= 1'b1;
        keeper_oe_o <= 1'b0;
      end else if (!fill) begin
        serial_data_output_o <= 1'b0;
        serial_data_output_oe_o <= 1'b1;
        keeper_oe_o <= 1'b0;
      end else begin
        // Level stays on the data output so the keeper holds the last bit
        serial_data_output_oe_o <= 1'b0;
        keeper_oe_o <= !kdis && (drove_q || (ctrl_q[`F_KEEP_LEN] && keeper_oe_o));
      end
    end else if (tx_half && last_q && ctrl_q[`F_KEEP_CY] && serial_data_output_oe_o) begin
      serial_data_output_oe_o <= 1'b0;
      keeper_oe_o <= !kdis;
      last_q <= 1'b0;
    end else if (kdis) begin
      keeper_oe_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_frame_restart;
    start |=> pos_q == 10'h000 && phase_q != tdm_pkg::WAIT_FRAME;
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("frame position not cleared");

  property p_rx_only_on_edge;
    !rx_tick |=> $stable(pos_q) && $stable(sh_a_q);
  endproperty
  a_rx_only_on_edge: assert property (p_rx_only_on_edge) else $error("rx moved off its edge");

  property p_slot0_at_delay;
    rx_tick && at_delay && (start || phase_q == tdm_pkg::OFFSET)
      |=> phase_q == tdm_pkg::SLOTS && sidx_q == 6'h00 && sbit_q == 6'h00;
  endproperty
  a_slot0_at_delay: assert property (p_slot0_at_delay) else $error("slot 0 misplaced");

  property p_slot_wrap;
    rx_tick && phase_q == tdm_pkg::SLOTS && !start && sbit_q == slen - 6'h01
      |=> sbit_q == 6'h00 && sidx_q == $past(sidx_q) + 6'h01 || $past(sidx_q) == 6'h3F;
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot length wrong");

  property p_null_sample;
    rx_tick && start && phase_q != tdm_pkg::WAIT_FRAME && !done_a_q
      |=> playback_valid_o && playback_sample_o == 32'h0000_0000;
  endproperty
  a_null_sample: assert property (p_null_sample) else $error("incomplete slot not muted");

  property p_tx_only_on_edge;
    !tx_tick && !tx_half && !pin_loop |=> $stable(serial_data_output_o);
  endproperty
  a_tx_only_on_edge: assert property (p_tx_only_on_edge) else $error("tx changed off edge");

  property p_fill_zero;
    tx_tick && !hit && !fill && !pin_loop |=> serial_data_output_oe_o && !serial_data_output_o;
  endproperty
  a_fill_zero: assert property (p_fill_zero) else $error("idle fill not zero");

  property p_keeper_off;
    kdis ##1 kdis |-> !keeper_oe_o;
  endproperty
  a_keeper_off: assert property (p_keeper_off) else $error("keeper on while disabled");

  property p_pin_loop;
    pin_loop |=> serial_data_output_oe_o && serial_data_output_o == $past(sd_s);
  endproperty
  a_pin_loop: assert property (p_pin_loop) else $error("pin loopback broken");

  property p_tx_truncate;
    tx_tick && tx_pend_q |=> tpos_q == 10'h000;
  endproperty
  a_tx_truncate: assert property (p_tx_truncate) else $error("tx frame not restarted");

  c_downmix: cover property (playback_valid_o && scfg == `SCFG_DOWNMIX && playback_sample_o != '0);
  c_pin_loop: cover property (pin_loop && serial_data_output_o);
  c_keeper: cover property (keeper_oe_o && !serial_data_output_oe_o);
  c_health: cover property (tx_tick && hit && st_en[3] && is_last);
endmodule
`default_nettype wire

// ==== src/tdm_cfg.svh ====
`ifndef TDM_CFG_SVH
`define TDM_CFG_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_RX_SLOTS 8'h04
`define OFS_TX_ENABLE 8'h08
`define OFS_TX_SLOTS 8'h0C
`define OFS_ECHO_SLOT 8'h10
`define OFS_STATUS 8'h14
`define OFS_PLAYBACK 8'h18

// Control register layout
`define CTRL_RESET 32'h0008_0000
`define F_FRAME_POL 0
`define F_RX_EDGE 1
`define F_RX_JUSTIFY 2
`define F_TX_EDGE 3
`define F_TX_FILL 4
`define F_KEEP_DIS 5
`define F_KEEP_LEN 6
`define F_KEEP_CY 7
`define F_PIN_LOOP 8
`define F_DESER_LOOP 9
`define F_RX_DELAY 10
`define F_TX_DELAY 15
`define F_RX_SLOT_LENGTH 18
`define F_RX_WORD_LENGTH 20
`define F_RX_SOURCE_CONFIG 22

// Receive slot select layout
`define F_SLOT_L 0
`define F_SLOT_R 4

// Transmit enable layout
`define F_EN_BOOST 0
`define F_EN_BATT 1
`define F_EN_TEMP 2
`define F_EN_HEALTH 3
`define F_EN_ECHO 4
`define F_LEN_BOOST 8
`define F_LEN_BATT 9
`define F_LEN_ECHO 10

// Transmit slot index layout
`define F_SLOT_BOOST 0
`define F_SLOT_BATT 8
`define F_SLOT_TEMP 16
`define F_SLOT_HEALTH 24
`define F_SLOT_ECHO 0

// Status layout
`define F_ST_RATE 0
`define F_ST_SLOTS 8

// Source select codes
`define SCFG_ADDR 2'h0
`define SCFG_LEFT 2'h1
`define SCFG_RIGHT 2'h2
`define SCFG_DOWNMIX 2'h3

// Bit counts
`define BITS_8 6'h08
`define BITS_16 6'h10
`define BITS_20 6'h14
`define BITS_24 6'h18
`define BITS_32 6'h20
`define TX_SLOT_SHIFT 3

// Sample rate codes and frame period limits in clk_i cycles
`define RATE_RESET 3'h4
`define RATE_ERR 3'h7
`define LIM_16K 14'h1964
`define LIM_24K 14'h1194
`define LIM_32K 14'h0C80
`define LIM_48K 14'h076C
`define LIM_96K 14'h03B6
`define LIM_192K 14'h0190

`endif

// ==== src/tdm_pkg.sv ====
`default_nettype none
package tdm_pkg;

  typedef enum logic [1:0] {
    WAIT_FRAME = 2'b00,
    OFFSET = 2'b01,
    SLOTS = 2'b10
  } rx_phase_e;

  // Bit 0 is the first field from the bottom
  typedef struct packed {
    logic device_active;
    logic y_bridge_high_supply;
    logic noise_gate;
    logic limiter_active;
    logic brownout_active;
    logic overtemperature;
    logic overcurrent;
    logic supply_undervoltage;
  } health_s;

  typedef struct packed {
    logic [31:0] echo_reference;
    health_s health;
    logic [15:0] die_temperature;
    logic [15:0] battery;
    logic [15:0] boost_supply;
  } tx_streams_s;

endpackage
`default_nettype wire

// ==== src/tdm_rate_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tdm_cfg.svh"
module tdm_rate_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_i,
  output logic [2:0] rate_o
);
  logic [13:0] cnt_q;
  logic seen_q;

  function automatic logic [2:0] classify(input logic [13:0] n);
    if (n > `LIM_16K) classify = 3'h1;
    else if (n > `LIM_24K) classify = 3'h2;
    else if (n > `LIM_32K) classify = 3'h3;
    else if (n > `LIM_48K) classify = 3'h4;
    else if (n > `LIM_96K) classify = 3'h5;
    else if (n > `LIM_192K) classify = 3'h6;
    else classify = `RATE_ERR;
  endfunction

  // Frame period measured in system clocks; the bit clock ratio does not matter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      seen_q <= 1'b0;
      rate_o <= `RATE_RESET;
    end else if (frame_i) begin
      cnt_q <= '0;
      seen_q <= 1'b1;
      if (seen_q) rate_o <= classify(cnt_q);
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== src/tdm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdm_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_tdm_audio_serial_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tdm_cfg.svh"
module tb_tdm_audio_serial_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [31:0] rd;
  logic bclk;
  logic fs;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic [31:0] sample;
  logic valid;
  logic keeper;
  logic ad_a = 1'b0;
  logic ad_b = 1'b1;
  tdm_pkg::tx_streams_s streams = '0;
  int n_mismatch = 0;
  int checks = 0;
  int n_valid = 0;

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (valid) n_valid <= n_valid + 1;
  end

  tdm_audio_serial_port dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wdat),
    .wb_sel_i(4'hF),
    .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack),
    .serial_bit_clock_i(bclk),
    .frame_sync_i(fs),
    .serial_data_input_i(sdi),
    .address_select_pin_a_i(ad_a),
    .address_select_pin_b_i(ad_b),
    .streams_i(streams),
    .playback_sample_o(sample),
    .playback_valid_o(valid),
    .serial_data_output_o(sdo),
    .serial_data_output_oe_o(sdo_oe),
    .keeper_oe_o(keeper)
  );

  tdm_host_model host (
    .bclk_o(bclk),
    .fs_o(fs),
    .sd_o(sdi),
    .sdo_i(sdo),
    .sdo_oe_i(sdo_oe)
  );

  task automatic wrap_up();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 64) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  // Second frame of a burst shows the first, so each config is judged alone
  task automatic play(input logic [31:0] c, input logic [31:0] s, input logic [31:0] e);
    bus(1'b1, `OFS_CTRL, c);
    bus(1'b1, `OFS_RX_SLOTS, s);
    host.run(2, 4);
    chk("playback", e, sample);
  endtask

  task automatic t_regs();
    rchk("ctrl", `OFS_CTRL, 32'h0008_0000);
    rchk("status", `OFS_STATUS, 32'h0000_0004);
    rchk("unmapped", 8'h40, 32'h0000_0000);
  endtask

  task automatic t_mono();
    bus(1'b1, `OFS_TX_ENABLE, 32'h0000_0008);
    bus(1'b1, `OFS_TX_SLOTS, 32'h0000_0000);
    host.run(2, 4);
    chk("mono", 32'h9ABC_0000, sample);
    chk("valid count", 32'h0000_0001, 32'(n_valid));
    bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk("slot count", 32'h0000_0004, 32'(rd[13:8]));
    chk("rate", 32'h0000_0004, 32'(rd[2:0]));
    chk("idle fill", 32'h0000_0000, 32'(host.cap_q[9]));
    for (int i = 0; i < 8; i++) begin
      chk("health", 32'(streams.health[7 - i]), 32'(host.cap_q[1 + i]));
    end
  endtask

  task automatic t_src();
    play(32'h0048_0000, 32'h0000_0015, 32'h0000_0000);
    play(32'h0088_0000, 32'h0000_0015, 32'hF000_0000);
    play(32'h00C8_0000, 32'h0000_0010, 32'h1000_0000);
    ad_a <= 1'b1;
    ad_b <= 1'b0;
    play(32'h0000_0000, 32'h0000_0000, 32'h0001_0000);
    ad_a <= 1'b0;
    ad_b <= 1'b1;
    play(32'h0028_0004, 32'h0000_0000, 32'hBCDE_F000);
    play(32'h0008_0450, 32'h0000_0000, 32'h3579_0000);
    chk("keeper", 32'h0000_0001, 32'(keeper));
  endtask

  task automatic t_loop();
    bus(1'b1, `OFS_CTRL, 32'h0008_0100);
    repeat (6) @(posedge clk_i);
    chk("loop data", 32'(sdi), 32'(sdo));
    chk("loop oe", 32'h0000_0001, 32'(sdo_oe));
  endtask

  initial begin
    streams.health = 8'hC4;
    host.word_q[0] = 32'h3000_0001;
    host.word_q[1] = 32'hF000_0002;
    host.word_q[2] = 32'h9ABC_DEF0;
    host.word_q[3] = 32'h0F0F_F0F0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_mono();
    t_src();
    t_loop();
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== test/tdm_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model (
  output logic bclk_o,
  output logic fs_o,
  output logic sd_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  logic [31:0] word_q [16];
  logic cap_q [512];
  // Bit clock stands still low between bursts; frame sync idles high
  initial begin
    bclk_o = 1'b0;
    fs_o = 1'b1;
    sd_o = 1'b0;
  end
  task automatic run(input int nf, input int ns);
    for (int f = 0; f < nf; f++) begin
      for (int k = 0; k < ns * 32; k++) begin
        fs_o <= (k == ns * 32 - 1);
        sd_o <= word_q[k / 32][31 - k % 32];
        #80 bclk_o <= 1'b1;
        #80 bclk_o <= 1'b0;
        cap_q[k] = sdo_oe_i ? sdo_i : 1'bz;
      end
    end
    // Released line shows the inverse, so a stale level never passes
    sd_o <= ~sd_o;
  endtask
endmodule
`default_nettype wire
